// File: src/hs_pkg.sv
// Overview of operation
// - Method 22: negative seek, stop on rise
// - Method 23 below/on: stop on sensor fall
// - Method 23 above: forward limit, clear, then fall
// - Method 24 below/on: stop on sensor rise
// - Method 24 above: limit, fast back, rise
// - Method 25 below/on: fall, creep, rise
// - Method 25 above: limit, clear, then rise
// - Method 26 below: clear, creep, stop fall
// - Method 26 on: stop on sensor fall; above: forward limit, then fall
// - Method 27 above/on: stop on sensor fall
// - Method 27 below: reverse limit, seek, fall
// - Method 28 above/on: stop on sensor rise
// - Method 28 below: reverse limit, stop rise
// - Method 29 above/on: stop on sensor rise
// - Method 29 below: reverse limit, seek, rise
// - Method 30 above/on: stop on sensor fall
// - Method 30 below: reverse limit, stop fall
// - Eight stored speeds chosen by select inputs
// - Speed comes from storage, never analog
// - Mode value 15 enables internal speed
// - Branch from sensor level at start
package hs_pkg;

	// ==========================================
	// Method numbering
	localparam logic [4:0] HS_METHOD_FIRST = 5'h16;
	localparam logic [4:0] HS_METHOD_LAST = 5'h1e;

	// ==========================================
	// Internal speed mode
	localparam logic [7:0] HS_MODE_INTERNAL_SPEED = 8'h0f;
	localparam int HS_SPEED_COUNT = 8;
	localparam int HS_SPEED_W = 8;
	localparam logic [HS_SPEED_W-1:0] HS_SPEED_RESET [HS_SPEED_COUNT] = '{8'h00, 8'h0a, 8'h14, 8'h19,
		8'h1e, 8'h23, 8'h28, 8'h32};
	localparam int HS_POS_W = 32;

	// ==========================================
	// Step table layout
	localparam int HS_STEPS = 4;
	localparam logic [1:0] HS_EV_RISE = 2'h0;
	localparam logic [1:0] HS_EV_FALL = 2'h1;
	localparam logic [1:0] HS_EV_FLIM = 2'h2;
	localparam logic [1:0] HS_EV_RLIM = 2'h3;
	localparam logic [1:0] HS_BR_ON = 2'h0;
	localparam logic [1:0] HS_BR_BELOW = 2'h1;
	localparam logic [1:0] HS_BR_ABOVE = 2'h2;

	typedef struct packed {
		logic valid;
		logic fwd;
		logic fast;
		logic [1:0] ev;
		logic pause;
	} hs_step_t;

	typedef hs_step_t [HS_STEPS-1:0] hs_seq_t;

	typedef struct packed {
		logic origin_sensor;
		logic forward_overtravel_limit;
		logic reverse_overtravel_limit;
	} hs_axis_in_t;

	typedef struct packed {
		logic run;
		logic fwd;
		logic fast;
	} hs_motion_t;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_RUN = 2'b01,
		HS_PAUSE = 2'b10
	} hs_state_t;

endpackage

// File: src/hs_homing_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module hs_homing_sequencer
	import hs_pkg::*;
(
	input wire logic clk_sys, // 250 MHz system clock
	input wire logic arst_n, // Asynchronous reset, active low
	input wire logic home_start, // One-cycle pulse starts homing
	input wire logic [4:0] home_method, // Homing method, 22 to 30
	input wire logic axis_above_sensor, // Axis lies on positive side of sensor
	input wire hs_axis_in_t axis_in, // Sensor and overtravel levels
	input wire logic axis_at_rest, // Motion has come to a standstill
	input wire logic [HS_POS_W-1:0] axis_position, // Present axis position
	input wire logic [7:0] main_control_mode_param, // Main control mode
	input wire logic speed_wr_en, // Write one stored speed
	input wire logic [2:0] speed_wr_idx, // Stored speed to write
	input wire logic [HS_SPEED_W-1:0] speed_wr_data, // Signed speed, rps
	input wire logic [2:0] speed_sel, // Digital speed select inputs
	output hs_motion_t motion_cmd, // Run, direction and speed class
	output logic home_busy, // Homing sequence in progress
	output logic home_done, // Origin found, level until next start
	output logic home_error, // Unsupported method requested
	output logic [HS_POS_W-1:0] origin_position, // Latched origin
	output logic internal_speed_active, // Internal speed mode selected
	output logic [HS_SPEED_W-1:0] speed_cmd // Active speed command
);

	// ==========================================
	// Step table
	function automatic hs_step_t mk(input logic fwd, input logic fast, input logic [1:0] ev, input logic pause);
		hs_step_t s;
		s.valid = 1'b1;
		s.fwd = fwd;
		s.fast = fast;
		s.ev = ev;
		s.pause = pause;
		return s;
	endfunction

	// One row per method and branch; a step ends at its edge, and a pause step stops before the next
	function automatic hs_seq_t seq_of(input logic [4:0] m, input logic [1:0] br);
		hs_seq_t q;
		q = '0;
		case (m)
			5'h16:
				if (br == HS_BR_ON)
				begin
					q[0] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_RISE, 1'b0);
				end
				else
				begin
					q[0] = mk(1'b0, 1'b1, HS_EV_RISE, 1'b0);
					q[1] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b1);
					q[2] = mk(1'b0, 1'b0, HS_EV_RISE, 1'b0);
				end
			5'h17:
				if (br == HS_BR_ON)
					q[0] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b0);
				else if (br == HS_BR_BELOW)
				begin
					q[0] = mk(1'b1, 1'b1, HS_EV_RISE, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b0);
				end
				else
				begin
					q[0] = mk(1'b1, 1'b1, HS_EV_FLIM, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b1);
					q[2] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b0);
				end
			5'h18:
				if (br == HS_BR_ON)
				begin
					q[0] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b0);
					q[1] = mk(1'b1, 1'b0, HS_EV_RISE, 1'b0);
				end
				else if (br == HS_BR_BELOW)
				begin
					q[0] = mk(1'b1, 1'b1, HS_EV_RISE, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b1);
					q[2] = mk(1'b1, 1'b0, HS_EV_RISE, 1'b0);
				end
				else
				begin
					q[0] = mk(1'b1, 1'b1, HS_EV_FLIM, 1'b0);
					q[1] = mk(1'b0, 1'b1, HS_EV_FALL, 1'b0);
					q[2] = mk(1'b1, 1'b0, HS_EV_RISE, 1'b0);
				end
			5'h19:
				if (br == HS_BR_ON)
				begin
					q[0] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_RISE, 1'b0);
				end
				else if (br == HS_BR_BELOW)
				begin
					q[0] = mk(1'b1, 1'b1, HS_EV_FALL, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_RISE, 1'b0);
				end
				else
				begin
					q[0] = mk(1'b1, 1'b1, HS_EV_FLIM, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b1);
					q[2] = mk(1'b0, 1'b0, HS_EV_RISE, 1'b0);
				end
			5'h1a:
				if (br == HS_BR_ON)
					q[0] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b0);
				else if (br == HS_BR_BELOW)
				begin
					q[0] = mk(1'b1, 1'b1, HS_EV_RISE, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b1);
					q[2] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b0);
				end
				else
				begin
					q[0] = mk(1'b1, 1'b1, HS_EV_FLIM, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b0);
				end
			5'h1b:
				if (br == HS_BR_ON)
					q[0] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b0);
				else if (br == HS_BR_ABOVE)
				begin
					q[0] = mk(1'b0, 1'b1, HS_EV_RISE, 1'b0);
					q[1] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b0);
				end
				else
				begin
					q[0] = mk(1'b0, 1'b1, HS_EV_RLIM, 1'b0);
					q[1] = mk(1'b1, 1'b1, HS_EV_RISE, 1'b0);
					q[2] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b1);
					q[3] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b0);
				end
			5'h1c:
				if (br == HS_BR_ON)
				begin
					q[0] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b0);
					q[1] = mk(1'b0, 1'b0, HS_EV_RISE, 1'b0);
				end
				else if (br == HS_BR_ABOVE)
				begin
					q[0] = mk(1'b0, 1'b1, HS_EV_RISE, 1'b0);
					q[1] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b1);
					q[2] = mk(1'b0, 1'b0, HS_EV_RISE, 1'b0);
				end
				else
				begin
					q[0] = mk(1'b0, 1'b1, HS_EV_RLIM, 1'b0);
					q[1] = mk(1'b1, 1'b0, HS_EV_RISE, 1'b0);
				end
			5'h1d:
				if (br == HS_BR_ON)
				begin
					q[0] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b0);
					q[1] = mk(1'b1, 1'b0, HS_EV_RISE, 1'b0);
				end
				else if (br == HS_BR_ABOVE)
				begin
					q[0] = mk(1'b0, 1'b1, HS_EV_FALL, 1'b0);
					q[1] = mk(1'b1, 1'b0, HS_EV_RISE, 1'b0);
				end
				else
				begin
					q[0] = mk(1'b0, 1'b1, HS_EV_RLIM, 1'b0);
					q[1] = mk(1'b1, 1'b1, HS_EV_RISE, 1'b0);
					q[2] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b1);
					q[3] = mk(1'b1, 1'b0, HS_EV_RISE, 1'b0);
				end
			5'h1e:
				if (br == HS_BR_ON)
					q[0] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b0);
				else if (br == HS_BR_ABOVE)
				begin
					q[0] = mk(1'b0, 1'b1, HS_EV_RISE, 1'b0);
					q[1] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b1);
					q[2] = mk(1'b0, 1'b0, HS_EV_FALL, 1'b0);
				end
				else
				begin
					q[0] = mk(1'b0, 1'b1, HS_EV_RLIM, 1'b0);
					q[1] = mk(1'b1, 1'b0, HS_EV_FALL, 1'b0);
				end
			default:
				q = '0;
		endcase
		return q;
	endfunction

	// ==========================================
	// Reset release
	logic [1:0] rst_sync;
	logic rst_n;

	// Release is synchronised so no flop leaves reset on a different edge
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// ==========================================
	// Edge detection
	hs_axis_in_t prev_in;
	logic sensor_rise;
	logic sensor_fall;
	logic flim_rise;
	logic rlim_rise;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			prev_in <= '0;
		else
			prev_in <= axis_in;
	end

	// Edges compare against the previous sample; inputs are already synchronous
	always_comb
	begin
		sensor_rise = axis_in.origin_sensor & ~prev_in.origin_sensor;
		sensor_fall = ~axis_in.origin_sensor & prev_in.origin_sensor;
		flim_rise = axis_in.forward_overtravel_limit & ~prev_in.forward_overtravel_limit;
		rlim_rise = axis_in.reverse_overtravel_limit & ~prev_in.reverse_overtravel_limit;
	end

	// ==========================================
	// Homing sequencer
	hs_state_t state;
	hs_state_t next_state;
	hs_seq_t seq;
	hs_seq_t next_seq;
	logic [1:0] step;
	logic [1:0] next_step;
	logic next_done;
	logic next_error;
	logic [HS_POS_W-1:0] next_origin;
	hs_step_t cur;
	hs_step_t nxt;
	logic hit;

	// Step advance; a start while busy is ignored, since the axis is already committed
	always_comb
	begin
		next_state = state;
		next_seq = seq;
		next_step = step;
		next_done = home_done;
		next_error = home_error;
		next_origin = origin_position;
		cur = seq[step];
		nxt = (step == 2'h3) ? hs_step_t'('0) : seq[step + 2'h1];
		case (cur.ev)
			HS_EV_RISE: hit = sensor_rise;
			HS_EV_FALL: hit = sensor_fall;
			HS_EV_FLIM: hit = flim_rise;
			default: hit = rlim_rise;
		endcase
		case (state)
			HS_IDLE:
				if (home_start)
				begin
					next_done = 1'b0;
					next_step = 2'h0;
					if (home_method < HS_METHOD_FIRST || home_method > HS_METHOD_LAST)
						next_error = 1'b1;
					else
					begin
						next_error = 1'b0;
						next_seq = seq_of(home_method, axis_in.origin_sensor ? HS_BR_ON :
							(axis_above_sensor ? HS_BR_ABOVE : HS_BR_BELOW));
						next_state = HS_RUN;
					end
				end
			HS_RUN:
				if (hit)
				begin
					if (!nxt.valid)
					begin
						next_origin = axis_position;
						next_done = 1'b1;
						next_state = HS_IDLE;
					end
					else
					begin
						next_step = step + 2'h1;
						next_state = cur.pause ? HS_PAUSE : HS_RUN;
					end
				end
			HS_PAUSE:
				if (axis_at_rest)
					next_state = HS_RUN;
			default:
				next_state = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= HS_IDLE;
			seq <= '0;
			step <= 2'h0;
			home_done <= 1'b0;
			home_error <= 1'b0;
			origin_position <= '0;
		end
		else
		begin
			state <= next_state;
			seq <= next_seq;
			step <= next_step;
			home_done <= next_done;
			home_error <= next_error;
			origin_position <= next_origin;
		end
	end

	// Motion follows the active step; halted in idle and while pausing
	assign motion_cmd.run = (state == HS_RUN);
	assign motion_cmd.fwd = (state == HS_RUN) & seq[step].fwd;
	assign motion_cmd.fast = (state == HS_RUN) & seq[step].fast;
	assign home_busy = (state != HS_IDLE);

	// ==========================================
	// Internal speed storage
	logic [HS_SPEED_W-1:0] speed_store [HS_SPEED_COUNT];
	logic [HS_SPEED_W-1:0] next_store [HS_SPEED_COUNT];
	logic next_active;
	logic [HS_SPEED_W-1:0] next_speed;

	// One write port per slot; a zero command when the mode is not selected
	genvar gi;
	generate
		for (gi = 0; gi < HS_SPEED_COUNT; gi++)
		begin : g_speed
			always_comb
			begin
				next_store[gi] = (speed_wr_en && speed_wr_idx == 3'(gi)) ? speed_wr_data : speed_store[gi];
			end
			always_ff @(posedge clk_sys or negedge rst_n)
			begin
				if (!rst_n)
					speed_store[gi] <= HS_SPEED_RESET[gi];
				else
					speed_store[gi] <= next_store[gi];
			end
		end
	endgenerate

	// Command is taken from storage only, so no analog input is needed
	always_comb
	begin
		next_active = (main_control_mode_param == HS_MODE_INTERNAL_SPEED);
		next_speed = next_active ? speed_store[speed_sel] : '0;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			internal_speed_active <= 1'b0;
			speed_cmd <= '0;
		end
		else
		begin
			internal_speed_active <= next_active;
			speed_cmd <= next_speed;
		end
	end

endmodule
`default_nettype wire

// File: sim/hs_homing_sequencer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module hs_homing_sequencer_properties
	import hs_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic arst_n, // Reset, active low
	input wire logic home_start, // Start pulse
	input wire logic [4:0] home_method, // Method
	input wire hs_axis_in_t axis_in, // Sensor, limits
	input wire logic [HS_POS_W-1:0] axis_position, // Position
	input wire logic [7:0] main_control_mode_param, // Mode
	input wire hs_motion_t motion_cmd, // Motion
	input wire logic home_busy, // Busy
	input wire logic home_done, // Done
	input wire logic home_error, // Error
	input wire logic [HS_POS_W-1:0] origin_position, // Origin
	input wire logic internal_speed_active, // Mode flag
	input wire logic [HS_SPEED_W-1:0] speed_cmd // Speed
);
	logic [2:0] rst_sh;
	logic [2:0] next_rst_sh;
	logic vm;
	logic go;
	// ==========================================
	// Helpers
	// Checks stay off until the design's synchronised reset has let go
	always_comb
	begin
		next_rst_sh = {rst_sh[1:0], 1'b1};
	end
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			rst_sh <= 3'h0;
		else
			rst_sh <= next_rst_sh;
	end
	// A start counts only while idle
	assign vm = home_method >= HS_METHOD_FIRST && home_method <= HS_METHOD_LAST;
	assign go = home_start && !home_busy;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_sh[2]);
	// ==========================================
	// Properties
	a_start_taken: assert property (go && vm |=> home_busy && motion_cmd.run)
		else $error("valid start not taken");
	a_bad_method: assert property (go && !vm |=> home_error && !home_busy)
		else $error("bad method not refused");
	a_on_first_step: assert property (go && vm && axis_in.origin_sensor |=> !motion_cmd.fast
		&& motion_cmd.fwd == ($past(home_method) inside {5'h16, 5'h19, 5'h1a, 5'h1b, 5'h1c}))
		else $error("wrong first step, sensor on");
	a_off_first_step: assert property (go && vm && !axis_in.origin_sensor |=> motion_cmd.fast
		&& motion_cmd.fwd == ($past(home_method) inside {5'h17, 5'h18, 5'h19, 5'h1a}))
		else $error("wrong first step, sensor off");
	a_done_halts: assert property ($rose(home_done) |-> !motion_cmd.run && !home_busy)
		else $error("motion after done");
	a_origin_latch: assert property ($rose(home_done) |-> origin_position == $past(axis_position))
		else $error("origin not latched");
	a_origin_holds: assert property (home_done && $past(home_done) |-> $stable(origin_position))
		else $error("origin moved");
	a_done_clears: assert property (go && vm |=> !home_done)
		else $error("done kept after start");
	a_speed_off: assert property (main_control_mode_param != 8'h0f |=> speed_cmd == 8'h00)
		else $error("speed outside internal mode");
	a_mode_flag: assert property (1'b1 |=> internal_speed_active == ($past(main_control_mode_param) == 8'h0f))
		else $error("mode flag wrong");
endmodule
bind hs_homing_sequencer hs_homing_sequencer_properties u_props (.clk_sys(clk_sys), .arst_n(arst_n),
	.home_start(home_start), .home_method(home_method), .axis_in(axis_in), .axis_position(axis_position),
	.main_control_mode_param(main_control_mode_param), .motion_cmd(motion_cmd), .home_busy(home_busy),
	.home_done(home_done), .home_error(home_error), .origin_position(origin_position),
	.internal_speed_active(internal_speed_active), .speed_cmd(speed_cmd));
`default_nettype wire

// File: sim/hs_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
module hs_axis_model
	import hs_pkg::*;
#(
	parameter int S_LO = 32'sh64,
	parameter int S_HI = 32'sh8c
)
(
	input wire logic clk_sys, // Clock
	input wire hs_motion_t motion_cmd, // Command
	input wire logic load_en, // Place axis
	input wire logic signed [31:0] load_pos, // Place value
	input wire logic slow_rest, // Long settle
	output hs_axis_in_t axis_in, // Sensor, limits
	output logic axis_at_rest, // Standstill
	output logic [HS_POS_W-1:0] axis_position // Position
);
	logic signed [31:0] pos;
	logic signed [31:0] step;
	logic [3:0] still = 4'h0;
	// Fast moves 4, slow 1 per cycle: fast runs overshoot edges as a real axis would
	assign step = motion_cmd.fast ? 32'sh4 : 32'sh1;
	always_ff @(posedge clk_sys)
	begin
		if (load_en)
			pos <= load_pos;
		else if (motion_cmd.run)
			pos <= motion_cmd.fwd ? pos + step : pos - step;
		still <= motion_cmd.run ? 4'h0 : (still == 4'hf ? still : still + 4'h1);
	end
	// Sensor is a band; limits sit at both ends of travel
	assign axis_in.origin_sensor = pos >= S_LO && pos <= S_HI;
	assign axis_in.forward_overtravel_limit = pos >= 32'shf0;
	assign axis_in.reverse_overtravel_limit = pos <= 32'sh0;
	assign axis_at_rest = still >= (slow_rest ? 4'h8 : 4'h1);
	assign axis_position = pos;
endmodule
`default_nettype wire

// File: sim/hs_homing_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hs_homing_sequencer_bench
	import hs_pkg::*;
;
	localparam logic signed [31:0] SLO = 32'sh64;
	localparam logic signed [31:0] SHI = 32'sh8c;
	logic clk_sys = 1'b0, arst_n = 1'b0, home_start = 1'b0, axis_above_sensor = 1'b0;
	logic speed_wr_en = 1'b0, load_en = 1'b1, slow_rest = 1'b0, done_q = 1'b0;
	logic [4:0] home_method = 5'h16;
	logic [7:0] mode = 8'h00, speed_wr_data = 8'h00;
	logic [2:0] speed_wr_idx = 3'h0, speed_sel = 3'h0;
	logic signed [31:0] load_pos = 32'sh32;
	logic [31:0] lfsr = 32'h661c;
	logic [31:0] q_org [$];
	hs_axis_in_t axis_in;
	hs_motion_t motion_cmd;
	logic axis_at_rest, home_busy, home_done, home_error, internal_speed_active;
	logic [31:0] axis_position, origin_position;
	logic [7:0] speed_cmd;
	int n_mismatch = 0;
	int n_compared = 0;
	// Method, start side (0 on, 1 below, 2 above), final edge kind
	logic [11:0] cases [24] = '{12'h169, 12'h161,
		12'h176, 12'h172,
		12'h184, 12'h180, 12'h188,
		12'h195, 12'h191,
		12'h1a7, 12'h1aa, 12'h1a3,
		12'h1bb, 12'h1b3, 12'h1b7,
		12'h1c9, 12'h1c1, 12'h1c4,
		12'h1d8, 12'h1d0, 12'h1d4,
		12'h1ea, 12'h1e2, 12'h1e7};

	hs_homing_sequencer u_hs_homing_sequencer (.clk_sys(clk_sys), .arst_n(arst_n), .home_start(home_start),
		.home_method(home_method), .axis_above_sensor(axis_above_sensor), .axis_in(axis_in),
		.axis_at_rest(axis_at_rest), .axis_position(axis_position), .main_control_mode_param(mode),
		.speed_wr_en(speed_wr_en), .speed_wr_idx(speed_wr_idx), .speed_wr_data(speed_wr_data),
		.speed_sel(speed_sel), .motion_cmd(motion_cmd), .home_busy(home_busy), .home_done(home_done),
		.home_error(home_error), .origin_position(origin_position),
		.internal_speed_active(internal_speed_active), .speed_cmd(speed_cmd));
	hs_axis_model #(.S_LO(SLO), .S_HI(SHI)) u_hs_axis_model (.clk_sys(clk_sys), .motion_cmd(motion_cmd),
		.load_en(load_en), .load_pos(load_pos), .slow_rest(slow_rest), .axis_in(axis_in),
		.axis_at_rest(axis_at_rest), .axis_position(axis_position));

	// ==========================================
	// Helpers
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cmp_pos(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_pos({24'h0, got}, {24'h0, exp});
	endtask
	task automatic tally_and_finish;
		$display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Place the axis (side 0 on, 1 below, 2 above) and start one method
	task automatic place_start(input logic [4:0] m, input logic [1:0] side);
		lfsr = next_rand(lfsr);
		@(posedge clk_sys);
		load_en <= 1'b1;
		load_pos <= side == 2'h0 ? 32'sh78 : (side == 2'h1 ? 32'sh32 : 32'shbe);
		axis_above_sensor <= side[1];
		slow_rest <= lfsr[0];
		@(posedge clk_sys);
		load_en <= 1'b0;
		repeat (2) @(posedge clk_sys);
		home_method <= m;
		home_start <= 1'b1;
		@(posedge clk_sys);
		home_start <= 1'b0;
	endtask
	// Run one method to done, noting the expected origin first
	task automatic run_case(input logic [11:0] c);
		int k;
		q_org.push_back(c[1] ? (c[0] ? SHI + 1 : SLO - 1) : (c[0] ? SHI : SLO));
		place_start(c[8:4], c[3:2]);
		k = 0;
		do
		begin
			@(negedge clk_sys);
			k++;
		end
		while (home_done !== 1'b1 && k < 3000);
		// A run that never finishes ends the test as a failure
		if (home_done !== 1'b1)
		begin
			n_mismatch++;
			tally_and_finish;
		end
	endtask
	// Above-side runs of 23 and 25 have no reachable final edge, so a mid-run reset ends them
	task automatic cut_case(input logic [4:0] m);
		int k;
		place_start(m, 2'h2);
		k = 0;
		do
		begin
			@(negedge clk_sys);
			k++;
		end
		while (axis_in.forward_overtravel_limit !== 1'b1 && k < 500);
		if (k >= 500)
			n_mismatch++;
		@(negedge clk_sys);
		cmp_byte({5'h0, motion_cmd}, 8'h04);
		k = 0;
		do
		begin
			@(negedge clk_sys);
			k++;
		end
		while (motion_cmd.run !== 1'b0 && k < 500);
		if (k >= 500)
			n_mismatch++;
		cmp_byte({6'h0, home_busy, axis_in.origin_sensor}, 8'h02);
		repeat (5) @(posedge clk_sys);
		arst_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp_byte({4'h0, motion_cmd, home_busy}, 8'h00);
	endtask
	task automatic bad_method(input logic [4:0] m);
		@(posedge clk_sys);
		home_method <= m;
		home_start <= 1'b1;
		@(posedge clk_sys);
		home_start <= 1'b0;
		@(negedge clk_sys);
		cmp_byte({7'h0, home_error}, 8'h01);
		cmp_byte({7'h0, home_busy}, 8'h00);
	endtask
	// Select a stored speed in a mode and look one cycle later
	task automatic spd(input logic [2:0] s, input logic [7:0] md, input logic [7:0] exp);
		@(posedge clk_sys);
		speed_wr_en <= 1'b0;
		speed_sel <= s;
		mode <= md;
		@(posedge clk_sys);
		@(negedge clk_sys);
		cmp_byte(speed_cmd, exp);
		cmp_byte({7'h0, internal_speed_active}, {7'h0, md == 8'h0f});
	endtask

	// ==========================================
	// Clock, monitor, watchdog, main sequence
	initial
	begin
		forever #2 clk_sys = ~clk_sys;
	end
	// Each new done takes the oldest noted origin
	always @(posedge clk_sys)
	begin
		done_q <= home_done;
		if (home_done === 1'b1 && done_q !== 1'b1)
			cmp_pos(origin_position, q_org.size() > 0 ? q_org.pop_front() : 32'hffffffff);
	end
	// Longest case runs under a thousand cycles, so this leaves ample margin
	initial
	begin
		#200000;
		n_mismatch++;
		tally_and_finish;
	end
	initial
	begin
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		foreach (cases[i])
			run_case(cases[i]);
		cut_case(5'h17);
		cut_case(5'h19);
		bad_method(5'h15);
		bad_method(5'h1f);
		for (int i = 0; i < HS_SPEED_COUNT; i++)
			spd(i[2:0], 8'h0f, HS_SPEED_RESET[i]);
		lfsr = next_rand(lfsr);
		@(posedge clk_sys);
		speed_wr_en <= 1'b1;
		speed_wr_idx <= lfsr[2:0];
		speed_wr_data <= lfsr[15:8];
		spd(lfsr[2:0], 8'h0f, lfsr[15:8]);
		spd(lfsr[2:0], 8'h0e, 8'h00);
		tally_and_finish;
	end
endmodule
`default_nettype wire
